// ---- shared/irea_defines.svh ----
// constants for the indexed/relative effective-address generator
// assumes byte-wide memory, 16-bit address space
`ifndef IREA_DEFINES_SVH
`define IREA_DEFINES_SVH
`define IREA_OP_LOAD_ACC_IX       8'hf6
`define IREA_OP_LOAD_ACC_IX1      8'he6
`define IREA_OP_LOAD_ACC_IX2      8'hd6
`define IREA_OP_BRANCH_IF_EQUAL   8'h27
`define IREA_OP_BRANCH_TO_SUB     8'had
`define IREA_CYC_LOAD_IX          3
`define IREA_CYC_LOAD_IX1         4
`define IREA_CYC_LOAD_IX2         5
`define IREA_PC_RESET    16'h0000
`define IREA_ZP_HIGH     8'h00
`define IREA_CC_C        0
`define IREA_CC_Z        1
`define IREA_CC_N        2
`define IREA_CC_I        3
`define IREA_CC_H        4
`endif

// ---- shared/irea_pkg.sv ----
// types for the indexed/relative effective-address generator
// assumes nothing beyond the defines header
package irea_pkg;
  typedef enum logic [1:0] {
    irea_mode_ix  = 2'b00,
    irea_mode_ix1 = 2'b01,
    irea_mode_ix2 = 2'b10,
    irea_mode_rel = 2'b11
  } irea_mode_e;

  typedef enum logic [2:0] {
    irea_st_fetch = 3'b000,
    irea_st_off_hi = 3'b001,
    irea_st_off_lo = 3'b010,
    irea_st_add   = 3'b011,
    irea_st_read  = 3'b100,
    irea_st_test  = 3'b101
  } irea_state_e;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
  } irea_mem_req_s;
endpackage

// ---- verilog/irea_gen.sv ----
// indexed / relative effective-address generator of an 8-bit cpu core
// assumes a byte memory answering reads combinationally in the same cycle
// Contract
// [RL1] no-offset address is zero-extended index
// [RL2] no-offset instruction is one opcode byte
// [RL3] f6 load: fetch, form, read; three cycles
// [RL4] 8-bit offset plus index, index unchanged
// [RL5] 8-bit offset unsigned, high base zero
// [RL6] 8-bit offset sum carries into high byte
// [RL7] e6 load: two bytes, four cycles
// [RL8] 16-bit offset plus zero-extended index
// [RL9] d6: high byte first, five cycles
// [RL10] relative only for branches; two bytes
// [RL11] signed offset added to next address
// [RL12] false continues; true loads target
// [RL13] 27 branches only when zero set
// [RL14] bit branches: direct address, relative offset
// [RL15] short indexed modes allow read-modify-write
// [RL16] 16-bit offset forbids read-modify-write
// [RL17] branch conditions list
// [RL18] 16-bit sums, carry kept, overflow dropped
`include "irea_defines.svh"
module irea_gen #(
  parameter int ADDR_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [7:0]        mem_rdata,
  input  wire logic [7:0]        index_reg,
  input  wire logic [7:0]        cc_flags,
  input  wire logic              irq_pin,
  output irea_pkg::irea_mem_req_s mem_req,
  output logic [ADDR_W-1:0]      effective_addr,
  output logic [ADDR_W-1:0]      pc,
  output logic [7:0]             acc,
  output logic                   acc_load,
  output logic                   illegal_op
);
  irea_pkg::irea_state_e state;
  irea_pkg::irea_state_e next_state;
  irea_pkg::irea_mode_e  mode;
  irea_pkg::irea_mode_e  next_mode;
  logic [7:0]            opcode;
  logic [7:0]            off_hi;
  logic [7:0]            off_lo;
  logic                  next_illegal;
  logic                  take_branch;
  logic [15:0]           next_pc_seq;
  logic [15:0]           branch_target;
  logic [15:0]           next_addr;

  function automatic logic [15:0] idx_sum(input logic [15:0] base, input logic [7:0] x);
    idx_sum = base + {8'h00, x}; // RL18
  endfunction

  function automatic logic branch_taken(input logic [7:0] op, input logic [7:0] cc, input logic irq);
    logic c;
    logic z;
    c = cc[`IREA_CC_C];
    z = cc[`IREA_CC_Z];
    unique case (op[3:1]) // RL17
      3'h0: branch_taken = 1'b1;
      3'h1: branch_taken = ~(c | z);
      3'h2: branch_taken = ~c;
      3'h3: branch_taken = ~z;
      3'h4: branch_taken = ~cc[`IREA_CC_H];
      3'h5: branch_taken = ~cc[`IREA_CC_N];
      3'h6: branch_taken = ~cc[`IREA_CC_I];
      3'h7: branch_taken = ~irq;
    endcase
    if (op[0]) begin
      branch_taken = ~branch_taken; // RL13
    end
  endfunction

  // opcode class decode: any low nibble in the register/memory rows, low nibbles other than 1, 2, 5, b and e in the rmw rows
  function automatic logic is_regmem(input logic [7:0] op);
    is_regmem = (op[7:4] == 4'hd) || (op[7:4] == 4'he) || (op[7:4] == 4'hf);
  endfunction

  function automatic logic is_rmw(input logic [7:0] op);
    is_rmw = (op[3:0] != 4'h1) && (op[3:0] != 4'h2) && (op[3:0] != 4'h5) && (op[3:0] != 4'hb)
          && (op[3:0] != 4'he);
  endfunction

  // accumulator loads sit in column 6 of the three indexed register/memory rows
  function automatic logic is_acc_load(input logic [7:0] op);
    is_acc_load = (op[3:0] == 4'h6) && (op[7:4] >= 4'hd);
  endfunction

  assign next_pc_seq = pc + 16'h0001;

  // pc already points past the branch when the target is formed
  assign branch_target = pc + {{8{off_lo[7]}}, off_lo}; // RL11

  // memory request: fetch at pc in fetch and offset states, operand at the address
  always_comb begin
    mem_req.rd = 1'b1;
    mem_req.addr = pc;
    if (state == irea_pkg::irea_st_read) begin
      mem_req.addr = effective_addr;
    end
  end

  // instruction decode: next state, addressing mode and refusal of the opcode
  always_comb begin
    next_state = irea_pkg::irea_st_fetch;
    next_mode = mode;
    next_illegal = 1'b0;
    unique case (state)
      irea_pkg::irea_st_fetch: begin
        unique casez (mem_rdata)
          8'hf?: begin
            next_mode = irea_pkg::irea_mode_ix; // RL2
            next_state = irea_pkg::irea_st_add;
          end
          8'he?: begin
            next_mode = irea_pkg::irea_mode_ix1;
            next_state = irea_pkg::irea_st_off_lo;
          end
          8'hd?: begin
            // only register/memory operations decode in the 16-bit offset row
            next_mode = irea_pkg::irea_mode_ix2;
            if (is_regmem(mem_rdata)) begin
              next_state = irea_pkg::irea_st_off_hi;
            end else begin
              next_illegal = 1'b1; // RL16
            end
          end
          8'h7?, 8'h6?: begin
            if (mem_rdata[4]) begin
              next_mode = irea_pkg::irea_mode_ix; // RL15
            end else begin
              next_mode = irea_pkg::irea_mode_ix1; // RL15
            end
            if (!is_rmw(mem_rdata)) begin
              next_illegal = 1'b1; // RL16
            end else if (mem_rdata[4]) begin
              next_state = irea_pkg::irea_st_add;
            end else begin
              next_state = irea_pkg::irea_st_off_lo;
            end
          end
          8'h2?, `IREA_OP_BRANCH_TO_SUB: begin
            next_mode = irea_pkg::irea_mode_rel; // RL10
            next_state = irea_pkg::irea_st_off_lo;
          end
          8'h0?: begin
            // bit test: direct byte first, relative byte second
            next_mode = irea_pkg::irea_mode_rel; // RL14
            next_state = irea_pkg::irea_st_off_hi;
          end
          default: begin
            next_state = irea_pkg::irea_st_fetch;
          end
        endcase
      end
      irea_pkg::irea_st_off_hi: begin
        next_state = irea_pkg::irea_st_off_lo;
      end
      irea_pkg::irea_st_off_lo: begin
        if (mode == irea_pkg::irea_mode_rel) begin
          next_state = irea_pkg::irea_st_test;
        end else begin
          next_state = irea_pkg::irea_st_add;
        end
      end
      irea_pkg::irea_st_add: begin
        next_state = irea_pkg::irea_st_read;
      end
      irea_pkg::irea_st_read: begin
        next_state = irea_pkg::irea_st_fetch;
      end
      irea_pkg::irea_st_test: begin
        next_state = irea_pkg::irea_st_fetch;
      end
      default: begin
        next_state = irea_pkg::irea_st_fetch;
      end
    endcase
  end

  // operand address per indexed mode
  always_comb begin
    unique case (mode)
      irea_pkg::irea_mode_ix: begin
        next_addr = {`IREA_ZP_HIGH, index_reg}; // RL1 RL3
      end
      irea_pkg::irea_mode_ix1: begin
        next_addr = idx_sum({`IREA_ZP_HIGH, off_lo}, index_reg); // RL4 RL5 RL6 RL7
      end
      irea_pkg::irea_mode_ix2: begin
        next_addr = idx_sum({off_hi, off_lo}, index_reg); // RL8
      end
      irea_pkg::irea_mode_rel: begin
        next_addr = pc;
      end
    endcase
  end

  // branch decision: subroutine always, condition branches, bit tests on carry
  always_comb begin
    take_branch = 1'b0;
    if (opcode == `IREA_OP_BRANCH_TO_SUB) begin
      take_branch = 1'b1;
    end else if (opcode[7:4] == 4'h2) begin
      take_branch = branch_taken(opcode, cc_flags, irq_pin); // RL13 RL17
    end else if (opcode[7:4] == 4'h0) begin
      take_branch = cc_flags[`IREA_CC_C] ^ opcode[0]; // RL14
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= irea_pkg::irea_st_fetch;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode <= irea_pkg::irea_mode_ix;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      illegal_op <= 1'b0;
    end else begin
      illegal_op <= next_illegal; // RL16
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opcode <= 8'h00;
    end else if (state == irea_pkg::irea_st_fetch) begin
      opcode <= mem_rdata;
    end
  end

  // the 16-bit offset arrives high byte first
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      off_hi <= 8'h00;
    end else if (state == irea_pkg::irea_st_off_hi) begin
      off_hi <= mem_rdata; // RL9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      off_lo <= 8'h00;
    end else if (state == irea_pkg::irea_st_off_lo) begin
      off_lo <= mem_rdata;
    end
  end

  // pc steps over every instruction byte; a taken branch reloads it
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pc <= `IREA_PC_RESET;
    end else if ((state == irea_pkg::irea_st_fetch) || (state == irea_pkg::irea_st_off_hi)
                 || (state == irea_pkg::irea_st_off_lo)) begin
      pc <= next_pc_seq;
    end else if ((state == irea_pkg::irea_st_test) && take_branch) begin
      pc <= branch_target; // RL12
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      effective_addr <= 16'h0000;
    end else if (state == irea_pkg::irea_st_add) begin
      effective_addr <= next_addr; // RL18
    end else if (state == irea_pkg::irea_st_test) begin
      effective_addr <= branch_target; // RL11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc <= 8'h00;
      acc_load <= 1'b0;
    end else begin
      acc_load <= 1'b0;
      if ((state == irea_pkg::irea_st_read) && is_acc_load(opcode)) begin
        acc <= mem_rdata; // RL3
        acc_load <= 1'b1;
      end
    end
  end
endmodule

// ---- test/irea_gen_asserts.sv ----
// checker for the effective-address generator ports
// assumes synchronous active-high reset and one clock
module irea_gen_asserts #(
  parameter int ADDR_W = 16
) (
  input wire logic                    sys_clk,
  input wire logic                    reset,
  input wire logic [7:0]              mem_rdata,
  input wire irea_pkg::irea_mem_req_s mem_req,
  input wire logic [ADDR_W-1:0]       effective_addr,
  input wire logic [ADDR_W-1:0]       pc,
  input wire logic [7:0]              acc,
  input wire logic                    acc_load,
  input wire logic                    illegal_op
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_rd_always: assert property (mem_req.rd)
    else $error("read strobe low");
  chk_load_gap: assert property (acc_load |=> !acc_load [*2])
    else $error("loads closer than three cycles");
  chk_load_at_addr: assert property (acc_load |-> $past(mem_req.addr) == effective_addr)
    else $error("operand not read at effective address");
  chk_acc_from_mem: assert property (acc_load |-> acc == $past(mem_rdata))
    else $error("acc differs from operand read");
  chk_acc_cause: assert property ($changed(acc) |-> acc_load || $past(acc_load) || $past(reset))
    else $error("acc changed without a load");
  chk_illegal_pulse: assert property (illegal_op |=> !illegal_op)
    else $error("refusal pulse too long");
  chk_illegal_noload: assert property (illegal_op |-> !acc_load)
    else $error("refused op loaded acc");
  chk_reset_vals: assert property ($fell(reset) |-> pc == 16'h0000 && acc == 8'h00 && !acc_load)
    else $error("bad state after reset");
endmodule
bind irea_gen irea_gen_asserts #(.ADDR_W(ADDR_W)) i_irea_gen_asserts (.*);

// ---- test/irea_mem_model.sv ----
// byte memory model answering reads in the same cycle
// assumes the generator only reads; bench fills it directly
module irea_mem_model (
  input  wire logic [15:0] addr,
  output logic [7:0]       rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'h9d;
  assign rdata = mem[addr];
endmodule

// ---- test/testbench.sv ----
// self-checking bench for the effective-address generator
// assumes irea_gen with a same-cycle byte memory model
`include "irea_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    sys_clk, reset, irq_pin, acc_load, illegal_op;
  logic [7:0]              index_reg, cc_flags, mem_rdata, acc;
  logic [15:0]             effective_addr, pc;
  irea_pkg::irea_mem_req_s mem_req;
  int                      n_errors = 0, checked = 0, cyc;
  irea_gen i_irea_gen (.sys_clk(sys_clk), .reset(reset), .mem_rdata(mem_rdata), .index_reg(index_reg),
    .cc_flags(cc_flags), .irq_pin(irq_pin), .mem_req(mem_req), .effective_addr(effective_addr),
    .pc(pc), .acc(acc), .acc_load(acc_load), .illegal_op(illegal_op));
  irea_mem_model i_irea_mem_model (.addr(mem_req.addr), .rdata(mem_rdata));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic put(input logic [15:0] a, input logic [7:0] v);
    i_irea_mem_model.mem[a] = v;
  endtask
  task automatic restart(input logic [7:0] x, input logic [7:0] cc, input logic irq);
    @(posedge sys_clk);
    reset <= 1'b1;
    index_reg <= x;
    cc_flags <= cc;
    irq_pin <= irq;
    @(posedge sys_clk);
    reset <= 1'b0;
  endtask
  task automatic t_load(input logic [7:0] op, b1, b2, x, input int n, input logic [15:0] exp_addr);
    put(16'h0000, op);
    put(16'h0001, b1);
    put(16'h0002, b2);
    put(exp_addr, exp_addr[7:0] ^ 8'h5a);
    restart(x, 8'h00, 1'b0);
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
    end while (acc_load !== 1'b1 && cyc < 20);
    // the load pulse stands in the cycle after the last of the n cycles
    cmp16("load cycles", 16'(n), 16'(cyc - 1));
    cmp16("acc", {8'h00, exp_addr[7:0] ^ 8'h5a}, {8'h00, acc});
    cmp16("effective_addr", exp_addr, effective_addr);
    cmp16("pc after load", 16'(n - 2), pc);
    $display("test load %h done", op);
  endtask
  task automatic t_branch(input logic [7:0] op, off, cc, input logic irq, input logic [15:0] exp);
    put(16'h0000, op);
    put(16'h0001, off);
    restart(8'h00, cc, irq);
    repeat (4) @(negedge sys_clk);
    cmp16("branch pc", exp, pc);
    $display("test branch %h %h done", op, off);
  endtask
  task automatic t_illegal(input logic [7:0] op, input logic exp);
    put(16'h0000, op);
    restart(8'h00, 8'h00, 1'b0);
    repeat (2) @(negedge sys_clk);
    cmp16("illegal_op", {15'h0000, exp}, {15'h0000, illegal_op});
    $display("test refusal %h done", op);
  endtask
  task automatic print_verdict();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // tests need under a hundred cycles; this limit is far beyond them
  initial begin
    #100us;
    n_errors++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    index_reg = 8'h00;
    cc_flags = 8'h00;
    irq_pin = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    t_load(`IREA_OP_LOAD_ACC_IX, 8'h00, 8'h00, 8'hff, `IREA_CYC_LOAD_IX, 16'h00ff);
    t_load(`IREA_OP_LOAD_ACC_IX1, 8'h05, 8'h00, 8'h00, `IREA_CYC_LOAD_IX1, 16'h0005);
    t_load(`IREA_OP_LOAD_ACC_IX1, 8'hff, 8'h00, 8'hff, `IREA_CYC_LOAD_IX1, 16'h01fe);
    t_load(`IREA_OP_LOAD_ACC_IX2, 8'h07, 8'h00, 8'h10, `IREA_CYC_LOAD_IX2, 16'h0710);
    t_load(`IREA_OP_LOAD_ACC_IX2, 8'hff, 8'hf0, 8'h20, `IREA_CYC_LOAD_IX2, 16'h0010);
    t_branch(`IREA_OP_BRANCH_IF_EQUAL, 8'hfc, 8'h02, 1'b0, 16'hfffe);
    t_branch(`IREA_OP_BRANCH_IF_EQUAL, 8'h7f, 8'h02, 1'b0, 16'h0081);
    t_branch(`IREA_OP_BRANCH_IF_EQUAL, 8'h10, 8'h00, 1'b0, 16'h0002);
    t_branch(8'h2f, 8'h10, 8'h00, 1'b1, 16'h0012);
    t_branch(8'h2e, 8'h10, 8'h00, 1'b1, 16'h0002);
    t_branch(8'h21, 8'h10, 8'h00, 1'b0, 16'h0002);
    t_branch(`IREA_OP_BRANCH_TO_SUB, 8'h08, 8'h00, 1'b0, 16'h000a);
    t_illegal(8'h61, 1'b1);
    t_illegal(8'hde, 1'b0);
    print_verdict();
  end
endmodule
